// ### core/cwr_pkg.sv
// Package for the CAN selective-wake clock recovery block.
// Holds register offsets, field layouts, reset values and timing constants.
package cwr_pkg;
  // AXI4-Lite byte offsets
  localparam logic [7:0] CWR_OFS_CTRL1 = 8'h00;   // recovery_control_one
  localparam logic [7:0] CWR_OFS_CTRL2 = 8'h04;   // recovery_control_two
  localparam logic [7:0] CWR_OFS_QUANTA = 8'h08;  // bit_quanta_count
  localparam logic [7:0] CWR_OFS_SAMPLE = 8'h0c;  // sample_point_setting
  localparam logic [7:0] CWR_OFS_LIM_HI = 8'h10;  // recovery_upper_limit
  localparam logic [7:0] CWR_OFS_LIM_LO = 8'h14;  // recovery_lower_limit
  localparam logic [7:0] CWR_OFS_MODE = 8'h18;    // can mode and power mode
  localparam logic [7:0] CWR_OFS_STATUS = 8'h1c;  // recovered quanta, state
  localparam logic [7:0] CWR_OFS_IRQ_ST = 8'h20;  // sticky events, w1c
  localparam logic [7:0] CWR_OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] CWR_OFS_WAKE = 8'h28;    // wake event request

  // Field positions
  localparam int CWR_BIT_ENABLE = 0;
  localparam int CWR_BIT_FILT_LO = 1;             // ctrl1 [2:1] filter
  localparam int CWR_BIT_SLEEP = 3;               // mode reg bit 3: 1 sleep, 0 stop
  localparam int CWR_NUM_IRQ = 4;
  localparam int CWR_IRQ_WAKE = 0;
  localparam int CWR_IRQ_SILENCE = 1;
  localparam int CWR_IRQ_LIMIT = 2;
  localparam int CWR_IRQ_BADCFG = 3;

  // Reset values
  localparam logic [2:0] CWR_CAN_OFF = 3'h0;
  localparam logic [7:0] CWR_RST_QUANTA = 8'h28;
  localparam logic [5:0] CWR_RST_SAMPLE = 6'h33;
  localparam logic [7:0] CWR_RST_LIM_HI = 8'h2c;
  localparam logic [7:0] CWR_RST_LIM_LO = 8'h24;
  localparam logic [1:0] CWR_RST_OSC_SEL = 2'h0;

  // Timing
  localparam int CWR_CLK_MHZ = 100;
  localparam int CWR_SILENCE_MS = 600;            // least 0.6 s, rounded up
  localparam int CWR_SILENCE_CYC = CWR_SILENCE_MS * 1000 * CWR_CLK_MHZ;
  localparam int CWR_WAKE_US = 100;               // longest reaction, rounded down
  localparam int CWR_WAKE_CYC = CWR_WAKE_US * CWR_CLK_MHZ;
  localparam int CWR_BIT_MIN_NS = 1000;           // 1 Mbit/s
  localparam int CWR_BIT_MIN_CYC = CWR_BIT_MIN_NS * CWR_CLK_MHZ / 1000;

  typedef struct packed {
    logic enable;
    logic [1:0] filter;
    logic [1:0] osc_sel;
    logic [7:0] quanta;
    logic [5:0] sample;
    logic [7:0] lim_hi;
    logic [7:0] lim_lo;
  } cwr_cfg_s;

  typedef struct packed {
    logic [7:0] recovered;
    logic limit_hit;
  } cwr_stat_s;
endpackage : cwr_pkg

// ### core/cwr_tracker.sv
// Bit-time tracker: measures recessive-to-dominant edge spacing on the
// synchronised receive line and steers the recovered quanta per bit.
// Assumes rx is already synchronised to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module cwr_tracker
  import cwr_pkg::*;
#(
  parameter int ACC_W = 20
) (
  input wire logic sys_clk,        // system clock
  input wire logic resetn,         // synchronous reset, low active
  input wire logic rx,             // synchronised bus level, 0 dominant
  input wire cwr_pkg::cwr_cfg_s cfg, // configuration
  output cwr_pkg::cwr_stat_s stat, // recovered quanta and limit pulse
  output logic sample_tick         // one pulse per bit at the sample point
);
  initial begin
    if (ACC_W < 16) $error("ACC_W too small");
  end

  logic [ACC_W-1:0] span_q;
  logic [ACC_W-1:0] pos_q;
  logic [7:0] rec_q;
  logic rx_q;
  logic limit_q;
  logic tick_q;

  // Clocks per quantum set by oscillator division
  wire [3:0] clk_per_tq = 4'h1 << cfg.osc_sel;
  wire [ACC_W-1:0] bit_clks = ACC_W'(rec_q) * ACC_W'(clk_per_tq);
  wire [ACC_W-1:0] sp_clks = ACC_W'((bit_clks * ACC_W'(cfg.sample)) >> 6);
  wire fall = rx_q & ~rx;
  // Measured bits spanned, rounded, over a falling edge pair
  wire [ACC_W-1:0] nbits = (bit_clks == '0) ? '0 : (span_q + (bit_clks >> 1)) / bit_clks;
  wire [ACC_W-1:0] meas = (nbits == '0) ? '0 : span_q / (nbits * ACC_W'(clk_per_tq));
  wire [7:0] meas_q8 = (meas > ACC_W'(8'hff)) ? 8'hff : meas[7:0];
  wire [7:0] filt_step = 8'h1 << cfg.filter;
  wire [7:0] step_up = (meas_q8 - rec_q > filt_step) ? filt_step : meas_q8 - rec_q;
  wire [7:0] step_dn = (rec_q - meas_q8 > filt_step) ? filt_step : rec_q - meas_q8;
  wire [7:0] next_rec = (meas_q8 > rec_q) ? rec_q + step_up :
                        (meas_q8 < rec_q) ? rec_q - step_dn : rec_q;
  wire over = (next_rec >= cfg.lim_hi) || (next_rec <= cfg.lim_lo);
  wire update = cfg.enable && fall && (nbits != '0) && (nbits < ACC_W'(6));

  always_ff @(posedge sys_clk) begin
    rx_q <= rx;
    limit_q <= 1'b0;
    if (!resetn) begin
      span_q <= '0;
      rec_q <= CWR_RST_QUANTA;
      rx_q <= 1'b1;
    end else if (!cfg.enable) begin
      rec_q <= cfg.quanta;
      span_q <= '0;
    end else begin
      // Restart at one so the span held at the next edge is the full edge spacing
      span_q <= fall ? ACC_W'(1) : span_q + 1'b1;
      if (update) begin
        if (over) begin
          rec_q <= cfg.quanta;
          limit_q <= 1'b1;
        end else begin
          rec_q <= next_rec;
        end
      end
    end
  end

  // Sample position inside each bit, resynchronised on every falling edge
  always_ff @(posedge sys_clk) begin
    tick_q <= 1'b0;
    if (!resetn || fall) begin
      pos_q <= '0;
    end else if (pos_q + 1'b1 >= bit_clks) begin
      pos_q <= '0;
    end else begin
      pos_q <= pos_q + 1'b1;
      tick_q <= (pos_q == sp_clks);
    end
  end

  assign stat.recovered = rec_q;
  assign stat.limit_hit = limit_q;
  assign sample_tick = tick_q;
endmodule : cwr_tracker
`default_nettype wire

// ### core/cwr_top.sv
// Clock recovery stage of the CAN selective-wake decoder, with AXI4-Lite
// register access, bus silence timer and wake reaction outputs.
// Assumes wake_req arrives from the frame matcher on sys_clk; can_rx is a pin.
// Overview of operation
// - single enable bit switches recovery on/off
// - measure bit stream, retune decoder timing
// - limit reached reloads programmed quanta
// - sample point default near eighty percent
// - bus silence timeout between 0.6 and 1.2s
// - react to wake within 100 us
// - wake: interrupt in Stop, regulator in Sleep
// - handle bit times down to 1 us
// - quanta per bit scaled by osc division
`timescale 1ns/100ps
`default_nettype none
module cwr_top
  import cwr_pkg::*;
#(
  parameter int SILENCE_CYC = CWR_SILENCE_CYC,
  parameter int WAKE_CYC = CWR_WAKE_CYC
) (
  input wire logic sys_clk,          // 100 MHz system clock
  input wire logic resetn,           // synchronous reset, low active
  input wire logic can_rx,           // CAN receive pin, 0 dominant
  input wire logic wake_req,         // valid wake pattern or frame seen (pulse)
  output logic wake_int,             // wake interrupt pin in Stop mode
  output logic regulator_restart,    // restart main_regulator_output from Sleep
  output logic bus_silent,           // bus inactive for the silence timeout
  output logic irq,                  // level interrupt
  input wire logic [31:0] s_axi_awaddr,  // write address
  input wire logic s_axi_awvalid,    // write address valid
  output logic s_axi_awready,        // write address ready
  input wire logic [31:0] s_axi_wdata,   // write data
  input wire logic [3:0] s_axi_wstrb,    // write strobes
  input wire logic s_axi_wvalid,     // write data valid
  output logic s_axi_wready,         // write data ready
  output logic [1:0] s_axi_bresp,    // write response
  output logic s_axi_bvalid,         // write response valid
  input wire logic s_axi_bready,     // write response ready
  input wire logic [31:0] s_axi_araddr,  // read address
  input wire logic s_axi_arvalid,    // read address valid
  output logic s_axi_arready,        // read address ready
  output logic [31:0] s_axi_rdata,   // read data
  output logic [1:0] s_axi_rresp,    // read response
  output logic s_axi_rvalid,         // read data valid
  input wire logic s_axi_rready      // read data ready
);
  initial begin
    if (SILENCE_CYC < 2 || WAKE_CYC < 2) $error("timing counts too small");
    if (CWR_BIT_MIN_CYC < 16) $error("clock too slow for 1 us bits");
    if (CWR_RST_QUANTA <= CWR_RST_LIM_LO || CWR_RST_QUANTA >= CWR_RST_LIM_HI) $error("reset quanta off limits");
  end

  // Configuration registers
  cwr_cfg_s cfg_q;
  logic [2:0] can_mode_q;
  logic sleep_q;
  logic [CWR_NUM_IRQ-1:0] irq_st_q;
  logic [CWR_NUM_IRQ-1:0] irq_mask_q;
  cwr_stat_s stat;
  logic sample_tick;

  // Pin synchroniser: only rx_s2 is read by logic
  logic rx_s1;
  logic rx_s2;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= can_rx;
      rx_s2 <= rx_s1;
    end
  end

  cwr_tracker #(.ACC_W(20)) u_track (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rx(rx_s2),
    .cfg(cfg_q),
    .stat(stat),
    .sample_tick(sample_tick)
  );

  // AXI4-Lite write path: address and data latched in either order
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire wr_ctrl1 = wr_go && aw_q == CWR_OFS_CTRL1;
  wire wr_ctrl2 = wr_go && aw_q == CWR_OFS_CTRL2;
  wire wr_quanta = wr_go && aw_q == CWR_OFS_QUANTA;
  wire wr_sample = wr_go && aw_q == CWR_OFS_SAMPLE;
  wire wr_lim_hi = wr_go && aw_q == CWR_OFS_LIM_HI;
  wire wr_lim_lo = wr_go && aw_q == CWR_OFS_LIM_LO;
  wire wr_mode = wr_go && aw_q == CWR_OFS_MODE;
  wire wr_irq_st = wr_go && aw_q == CWR_OFS_IRQ_ST;
  wire wr_irq_mask = wr_go && aw_q == CWR_OFS_IRQ_MASK;
  wire wr_wake = wr_go && aw_q == CWR_OFS_WAKE;
  wire wr_hit = wr_ctrl1 | wr_ctrl2 | wr_quanta | wr_sample | wr_lim_hi | wr_lim_lo | wr_mode |
                wr_irq_st | wr_irq_mask | wr_wake | (wr_go && aw_q == CWR_OFS_STATUS);
  wire lane0 = ws_q[0];

  // Each half waits in its holding register until the other has arrived
  always_ff @(posedge sys_clk) begin
    if (!resetn || wr_go) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_q | aw_take;
      w_hold_q <= w_hold_q | w_take;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      aw_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
    end else begin
      if (aw_take) aw_q <= {s_axi_awaddr[7:2], 2'h0};
      if (w_take) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
    end
  end

  // Ready stays low until the response is taken, so one write at a time
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= ~aw_hold_q & ~aw_take & ~s_axi_bvalid & ~wr_go;
      s_axi_wready <= ~w_hold_q & ~w_take & ~s_axi_bvalid & ~wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register stores; only byte lane 0 carries data in every register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cfg_q.enable <= 1'b0;
      cfg_q.filter <= 2'h0;
      cfg_q.osc_sel <= CWR_RST_OSC_SEL;
      cfg_q.quanta <= CWR_RST_QUANTA;
      cfg_q.sample <= CWR_RST_SAMPLE;
      cfg_q.lim_hi <= CWR_RST_LIM_HI;
      cfg_q.lim_lo <= CWR_RST_LIM_LO;
    end else if (lane0) begin
      if (wr_ctrl1) begin
        cfg_q.enable <= wd_q[CWR_BIT_ENABLE];
        cfg_q.filter <= wd_q[CWR_BIT_FILT_LO+:2];
      end
      if (wr_ctrl2) cfg_q.osc_sel <= wd_q[1:0];
      if (wr_quanta) cfg_q.quanta <= wd_q[7:0];
      if (wr_sample) cfg_q.sample <= wd_q[5:0];
      if (wr_lim_hi) cfg_q.lim_hi <= wd_q[7:0];
      if (wr_lim_lo) cfg_q.lim_lo <= wd_q[7:0];
    end
  end

  // Mode is only watched here, for the wake target and the enable guard
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      can_mode_q <= CWR_CAN_OFF;
      sleep_q <= 1'b0;
    end else if (lane0 && wr_mode) begin
      can_mode_q <= wd_q[2:0];
      sleep_q <= wd_q[CWR_BIT_SLEEP];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_mask_q <= '0;
    end else if (lane0 && wr_irq_mask) begin
      irq_mask_q <= wd_q[CWR_NUM_IRQ-1:0];
    end
  end

  // Bus silence timer, restarted by any dominant level
  logic [$clog2(SILENCE_CYC+1)-1:0] sil_cnt_q;
  logic silent_q;
  wire sil_done = sil_cnt_q == ($clog2(SILENCE_CYC+1))'(SILENCE_CYC - 1);
  always_ff @(posedge sys_clk) begin
    if (!resetn || !rx_s2) begin
      sil_cnt_q <= '0;
      silent_q <= 1'b0;
    end else if (!silent_q) begin
      sil_cnt_q <= sil_cnt_q + 1'b1;
      silent_q <= sil_done;
    end
  end

  // Wake reaction: outputs follow request within a few cycles, far inside the bound
  logic wake_int_q;
  logic regulator_q;
  wire wake_evt = wake_req | (wr_wake & lane0 & wd_q[0]);
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wake_int_q <= 1'b0;
    end else begin
      wake_int_q <= wake_evt & ~sleep_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      regulator_q <= 1'b0;
    end else begin
      regulator_q <= wake_evt & sleep_q;
    end
  end

  // Sticky event flags; a set in the same cycle wins over the write-one clear
  wire [CWR_NUM_IRQ-1:0] ev_set;
  assign ev_set[CWR_IRQ_WAKE] = wake_evt;
  assign ev_set[CWR_IRQ_SILENCE] = sil_done & ~silent_q & rx_s2;
  assign ev_set[CWR_IRQ_LIMIT] = stat.limit_hit;
  assign ev_set[CWR_IRQ_BADCFG] = wr_ctrl1 & lane0 & (can_mode_q != CWR_CAN_OFF);
  wire [CWR_NUM_IRQ-1:0] ev_clr = (wr_irq_st & lane0) ? wd_q[CWR_NUM_IRQ-1:0] : '0;
  wire [CWR_NUM_IRQ-1:0] irq_st_d = (irq_st_q & ~ev_clr) | ev_set;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= irq_st_d;
    end
  end

  // Built from the next status so the pin follows a clear without a lag
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_d & irq_mask_q);
    end
  end

  // Read path
  logic [31:0] rd_mux;
  wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ra)
      CWR_OFS_CTRL1: rd_mux[2:0] = {cfg_q.filter, cfg_q.enable};
      CWR_OFS_CTRL2: rd_mux[1:0] = cfg_q.osc_sel;
      CWR_OFS_QUANTA: rd_mux[7:0] = cfg_q.quanta;
      CWR_OFS_SAMPLE: rd_mux[5:0] = cfg_q.sample;
      CWR_OFS_LIM_HI: rd_mux[7:0] = cfg_q.lim_hi;
      CWR_OFS_LIM_LO: rd_mux[7:0] = cfg_q.lim_lo;
      CWR_OFS_MODE: rd_mux[3:0] = {sleep_q, can_mode_q};
      CWR_OFS_STATUS: rd_mux[9:0] = {silent_q, rx_s2, stat.recovered};
      CWR_OFS_IRQ_ST: rd_mux[CWR_NUM_IRQ-1:0] = irq_st_q;
      CWR_OFS_IRQ_MASK: rd_mux[CWR_NUM_IRQ-1:0] = irq_mask_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  wire rd_hit = ra <= CWR_OFS_WAKE;
  wire ar_take = s_axi_arvalid & s_axi_arready;

  // No new address is taken while read data waits for the master
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign wake_int = wake_int_q;
  assign regulator_restart = regulator_q;
  assign bus_silent = silent_q;
endmodule : cwr_top
`default_nettype wire

// ### sim/cwr_checker.sv
// Checker for the clock recovery block, bound onto the top module's ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module cwr_checker #(
  parameter int SILENCE_CYC = 200
) (
  input wire logic sys_clk,            // clock
  input wire logic resetn,             // reset, low active
  input wire logic can_rx,             // bus pin
  input wire logic wake_req,           // wake request
  input wire logic wake_int,           // Stop wake pulse
  input wire logic regulator_restart,  // Sleep wake pulse
  input wire logic bus_silent,         // silence level
  input wire logic s_axi_wvalid,       // write data valid
  input wire logic s_axi_bvalid,       // response valid
  input wire logic s_axi_bready,       // response ready
  input wire logic [1:0] s_axi_bresp,  // write response
  input wire logic s_axi_arvalid,      // read address valid
  input wire logic s_axi_arready,      // read address ready
  input wire logic s_axi_rvalid,       // read data valid
  input wire logic s_axi_rready,       // read data ready
  input wire logic [31:0] s_axi_rdata  // read data
);
  int rec_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Raw recessive run length; the design's synchroniser adds a few cycles
  always_ff @(posedge sys_clk) begin
    if (!resetn || !can_rx) rec_q <= 0;
    else if (rec_q < SILENCE_CYC + 100) rec_q <= rec_q + 1;
  end
  a_wake_react: assert property (wake_req |=> $onehot({wake_int, regulator_restart}))
    else $error("wake request gave no single wake pulse");
  a_wake_quiet: assert property ((!wake_req && !s_axi_wvalid && !s_axi_bvalid) [*3]
    |-> !wake_int && !regulator_restart) else $error("wake pulse without a cause");
  a_silent_rise: assert property ($rose(bus_silent) |-> rec_q >= SILENCE_CYC && rec_q <= SILENCE_CYC + 5)
    else $error("silence flagged at the wrong time");
  a_silent_fall: assert property (!can_rx [*5] |-> !bus_silent)
    else $error("silence kept during dominant bus");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h0)
    else $error("unused read bits not zero");
  a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("illegal write response");
endmodule : cwr_checker
bind cwr_top cwr_checker #(.SILENCE_CYC(SILENCE_CYC)) u_cwr_checker (
  .sys_clk, .resetn, .can_rx, .wake_req, .wake_int, .regulator_restart, .bus_silent,
  .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);
`default_nettype wire

// ### sim/cwr_can_node.sv
// CAN node model driving the receive line with repeated 16-bit frames.
// Assumes send() is called just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module cwr_can_node (
  input wire logic sys_clk,  // clock
  output logic can_rx        // bus level, 1 recessive
);
  initial can_rx = 1'h1;  // Termination pulls an idle bus recessive
  task automatic send(input logic [15:0] bits, input int bit_cyc, input int frames);
    for (int f = 0; f < frames; f++) begin
      for (int i = 15; i >= 0; i--) begin
        can_rx <= bits[i];
        repeat (bit_cyc) @(posedge sys_clk);
      end
    end
    can_rx <= 1'h1;
  endtask : send
endmodule : cwr_can_node
`default_nettype wire

// ### sim/cwr_top_tb.sv
// Bench for the clock recovery block: registers, recovery, limits, wake, silence.
// Assumes the node model and the bound checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module cwr_top_tb;
  import cwr_pkg::*;
  localparam int SIL = 300;
  typedef struct {
    logic [7:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } cwr_row_s;
  logic sys_clk, resetn, wake_req, wake_int, regulator_restart, bus_silent, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd, ni, nr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  wire can_rx;
  int errors, n_compared, n;
  cwr_row_s rows [13] = '{
    '{CWR_OFS_IRQ_ST, 1'h0, 32'h0, 32'h0, 2'h0},
    '{CWR_OFS_CTRL1, 1'h0, 32'h0, 32'h0, 2'h0},
    '{CWR_OFS_CTRL2, 1'h0, 32'h0, 32'(CWR_RST_OSC_SEL), 2'h0},
    '{CWR_OFS_QUANTA, 1'h0, 32'h0, 32'(CWR_RST_QUANTA), 2'h0},
    '{CWR_OFS_SAMPLE, 1'h0, 32'h0, 32'(CWR_RST_SAMPLE), 2'h0},
    '{CWR_OFS_LIM_HI, 1'h0, 32'h0, 32'(CWR_RST_LIM_HI), 2'h0},
    '{CWR_OFS_LIM_LO, 1'h0, 32'h0, 32'(CWR_RST_LIM_LO), 2'h0},
    '{CWR_OFS_MODE, 1'h0, 32'h0, 32'(CWR_CAN_OFF), 2'h0},
    '{CWR_OFS_IRQ_MASK, 1'h0, 32'h0, 32'h0, 2'h0},
    '{CWR_OFS_SAMPLE, 1'h1, 32'hffff_ff3f, 32'h3f, 2'h0},
    '{CWR_OFS_LIM_LO, 1'h1, 32'h0000_ab20, 32'h20, 2'h0},
    '{8'h40, 1'h1, 32'h5, 32'h0, 2'h2},
    '{8'h40, 1'h0, 32'h0, 32'h0, 2'h2}
  };
  cwr_top #(.SILENCE_CYC(SIL)) u_cwr_top (
    .sys_clk, .resetn, .can_rx, .wake_req, .wake_int, .regulator_restart, .bus_silent, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  cwr_can_node u_cwr_can_node (.sys_clk, .can_rx);
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Counting pulses keeps a one-cycle wake pulse from slipping past a poll
  always @(posedge sys_clk) begin
    ni <= ni + wake_int;
    nr <= nr + regulator_restart;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t seen %h want %h", $time, s, e);
    end
  endtask : check
  task automatic give_verdict();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic tmo();
    errors++;
    give_verdict();
  endtask : tmo
  // One transfer; the idle edge first keeps two drives of a valid apart
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_araddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    forever begin
      @(posedge sys_clk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
        rd = s_axi_rdata;
        rsp = w ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        break;
      end
      if (k > 200) tmo();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    bus(1'h0, a, 32'h0);
  endtask : rd_reg
  task automatic wake_chk(input logic [31:0] m, input logic sw);
    logic [31:0] bi, br;
    wr(CWR_OFS_MODE, m);
    bi = ni;
    br = nr;
    if (sw) wr(CWR_OFS_WAKE, 32'h1);
    else begin
      wake_req <= 1'h1;
      @(posedge sys_clk);
      wake_req <= 1'h0;
    end
    repeat (20) @(posedge sys_clk);
    check(ni - bi, {31'h0, !m[CWR_BIT_SLEEP]});
    check(nr - br, {31'h0, m[CWR_BIT_SLEEP]});
  endtask : wake_chk
  initial begin
    {errors, n_compared, ni, nr} = '0;
    {resetn, wake_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge sys_clk);
    check({wake_int, regulator_restart, bus_silent, irq, s_axi_bvalid, s_axi_rvalid}, 32'h0);
    resetn <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
        check(rsp, rows[i].r);
      end
      rd_reg(rows[i].a);
      check(rsp, rows[i].r);
      if (rows[i].r == 2'h0) check(rd, rows[i].e);
    end
    wr(CWR_OFS_MODE, 32'h0);
    wr(CWR_OFS_CTRL2, 32'h2);
    wr(CWR_OFS_QUANTA, 32'h28);
    wr(CWR_OFS_LIM_HI, 32'h2c);
    wr(CWR_OFS_LIM_LO, 32'h24);
    wr(CWR_OFS_SAMPLE, 32'h33);
    wr(CWR_OFS_CTRL1, 32'h3);
    wr(CWR_OFS_IRQ_ST, 32'hf);
    wr(CWR_OFS_IRQ_MASK, 32'h4);
    // 42 quanta of 4 clocks a bit, inside the limits
    u_cwr_can_node.send(16'h5555, 168, 4);
    rd_reg(CWR_OFS_STATUS);
    check(rd[7:0] > 8'h28, 1'h1);
    check(rd[7:0] < 8'h2c, 1'h1);
    check(irq, 1'h0);
    // 48 quanta a bit: the first measurement at this rate steps the estimate onto the upper limit
    u_cwr_can_node.send(16'h5555, 192, 4);
    check(irq, 1'h1);
    rd_reg(CWR_OFS_STATUS);
    check(rd[7:0] >= 8'h24 && rd[7:0] <= 8'h2c, 1'h1);
    wr(CWR_OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge sys_clk);
    check(irq, 1'h0);
    wr(CWR_OFS_IRQ_ST, 32'h4);
    rd_reg(CWR_OFS_IRQ_ST);
    check(rd[2], 1'h0);
    wr(CWR_OFS_CTRL1, 32'h0);
    rd_reg(CWR_OFS_STATUS);
    check(rd[7:0], 8'h28);
    wr(CWR_OFS_MODE, 32'h1);
    wr(CWR_OFS_CTRL1, 32'h1);
    rd_reg(CWR_OFS_IRQ_ST);
    check(rd[3], 1'h1);
    wr(CWR_OFS_MODE, 32'h0);
    wr(CWR_OFS_CTRL1, 32'h0);
    u_cwr_can_node.send(16'hfffe, 100, 1);
    check(bus_silent, 1'h0);
    for (n = 0; n < 1000 && bus_silent !== 1'h1; n++) @(posedge sys_clk);
    if (n >= 1000) tmo();
    check(n >= SIL && n <= SIL + 6, 1'h1);
    wake_chk(32'h0, 1'h0);
    wake_chk(32'h8, 1'h0);
    wake_chk(32'h0, 1'h1);
    wake_chk(32'h8, 1'h1);
    wr(CWR_OFS_QUANTA, 32'h30);
    resetn <= 1'h0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'h1;
    rd_reg(CWR_OFS_QUANTA);
    check(rd, 32'(CWR_RST_QUANTA));
    give_verdict();
  end
endmodule : cwr_top_tb
`default_nettype wire
